// file: core/mioe_pkg.sv
// Package for the move, OR and increment-skip execution datapath
package mioe_pkg;
  localparam int MIOE_DW = 8;
  localparam int MIOE_AW = 7;
  localparam logic [7:0] MIOE_W_RST = 8'h00;
  localparam logic MIOE_Z_RST = 1'b0;
  localparam logic [7:0] MIOE_ZERO = 8'h00;
  localparam logic [7:0] MIOE_ONE = 8'h01;
  localparam logic MIOE_DEST_W = 1'b0;
  localparam logic MIOE_DEST_F = 1'b1;

  // Operation select, decoded upstream
  typedef enum logic [2:0] {
    MIOE_OP_NOP,
    MIOE_OP_INC_SKIP,
    MIOE_OP_OR_LIT,
    MIOE_OP_LOAD_LIT,
    MIOE_OP_OR_FILE,
    MIOE_OP_STORE_W,
    MIOE_OP_MOVE_FILE
  } mioe_op_t;

  // One issued instruction
  typedef struct packed {
    mioe_op_t op;
    logic [MIOE_AW-1:0] addr;
    logic dest;
    logic [MIOE_DW-1:0] lit;
  } mioe_instr_t;

  // File register write request
  typedef struct packed {
    logic en;
    logic [MIOE_AW-1:0] addr;
    logic [MIOE_DW-1:0] data;
  } mioe_fwr_t;
endpackage

// file: core/mioe_zero_flag.sv
// Zero flag register with update enable
`timescale 1ns/1ps
module mioe_zero_flag
  import mioe_pkg::*;
(
  input wire logic ref_clk, // Core clock
  input wire logic rstn, // Sync reset, active low
  input wire logic upd, // Update strobe
  input wire logic [7:0] res, // Result to test
  output logic zero_r // Zero flag
);
  // Set on zero result, clear otherwise
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      zero_r <= MIOE_Z_RST;
    end else if (upd) begin
      zero_r <= (res == MIOE_ZERO); // RQ10
    end
  end
endmodule

// file: core/mioe_datapath.sv
// Execution datapath for move, OR, increment-skip and no-operation
//
// Behaviour
// RQ1 - Increment-skip adds one to the file value, writes W or the file by dest, flags unchanged.
// RQ2 - A zero increment result turns the next instruction into a no-operation.
// RQ3 - OR-literal ORs W with the literal into W and updates zero.
// RQ4 - Load-literal puts the literal in W and touches no flag.
// RQ5 - Software encodes the unused load-literal opcode bits as zero.
// RQ6 - OR-file ORs W with the file value into W or the file by dest and updates zero.
// RQ7 - Store-working copies W into the addressed file and touches no flag.
// RQ8 - Move-file copies the file value to W or back to the file by dest.
// RQ9 - Move-file updates zero in both destination cases.
// RQ10 - Zero is set on an 8-bit zero result, and increment of ff wraps to zero.
// RQ11 - No-operation changes no register, flag or file.
`timescale 1ns/1ps
module mioe_datapath
  import mioe_pkg::*;
(
  input wire logic ref_clk, // Core clock, one instruction cycle per enable
  input wire logic rstn, // Sync reset, active low
  input wire logic cycEn, // Instruction cycle enable pulse
  input wire mioe_instr_t instr, // Decoded instruction
  input wire logic [7:0] fileRd, // Addressed file register value
  output mioe_fwr_t fileWr, // File write request
  output logic [7:0] wReg_r, // Working register
  output logic zero_r, // Zero flag
  output logic skipNext_r // Next instruction is squashed
);
  logic [7:0] result;
  logic squash;
  logic wrW;
  logic wrF;
  logic updZ;
  logic zeroFlag;
  mioe_fwr_t fileWr_nxt;

  // Pending skip turns the instruction in hand into a no-operation
  assign squash = skipNext_r;

  // Result and write selection
  always_comb begin
    result = MIOE_ZERO;
    wrW = 1'b0;
    wrF = 1'b0;
    updZ = 1'b0;
    unique case (instr.op)
      MIOE_OP_NOP: begin
        result = MIOE_ZERO; // RQ11
      end
      MIOE_OP_INC_SKIP: begin
        result = fileRd + MIOE_ONE; // RQ1 RQ10
        wrW = (instr.dest == MIOE_DEST_W);
        wrF = (instr.dest == MIOE_DEST_F);
      end
      MIOE_OP_OR_LIT: begin
        result = wReg_r | instr.lit; // RQ3
        wrW = 1'b1;
        updZ = 1'b1;
      end
      MIOE_OP_LOAD_LIT: begin
        result = instr.lit; // RQ4
        wrW = 1'b1;
      end
      MIOE_OP_OR_FILE: begin
        result = wReg_r | fileRd; // RQ6
        wrW = (instr.dest == MIOE_DEST_W);
        wrF = (instr.dest == MIOE_DEST_F);
        updZ = 1'b1;
      end
      MIOE_OP_STORE_W: begin
        result = wReg_r; // RQ7
        wrF = 1'b1;
      end
      MIOE_OP_MOVE_FILE: begin
        result = fileRd; // RQ8
        wrW = (instr.dest == MIOE_DEST_W);
        wrF = (instr.dest == MIOE_DEST_F);
        updZ = 1'b1; // RQ9
      end
      default: begin
        result = MIOE_ZERO;
      end
    endcase
  end

  // Working register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      wReg_r <= MIOE_W_RST;
    end else if (cycEn && !squash && wrW) begin
      wReg_r <= result;
    end
  end

  // File write request, one cycle pulse
  always_comb begin
    fileWr_nxt.en = cycEn && !squash && wrF;
    fileWr_nxt.addr = instr.addr;
    fileWr_nxt.data = result;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      fileWr <= '0;
    end else begin
      fileWr <= fileWr_nxt;
    end
  end

  // Skip on zero increment result
  // A squashed instruction can never arm a new skip, so an increment that
  // lands in the shadow of another skip is dropped whole, result and all
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      skipNext_r <= 1'b0;
    end else if (cycEn) begin
      skipNext_r <= !squash && (instr.op == MIOE_OP_INC_SKIP)
        && (result == MIOE_ZERO); // RQ2
    end
  end

  mioe_zero_flag zeroU (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .upd(cycEn && !squash && updZ),
    .res(result),
    .zero_r(zeroFlag)
  );
  assign zero_r = zeroFlag;

  // Checks on the core clock; an instruction executes on an unsquashed enable
  logic execNow;
  assign execNow = cycEn && !squash;

  // Skip arming, holding and clearing
  inc_wrap_skip_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ2
    execNow && instr.op == MIOE_OP_INC_SKIP && fileRd == ~MIOE_ZERO
    |=> skipNext_r)
    else $error("zero increment did not arm skip");
  inc_no_skip_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ2
    execNow && instr.op == MIOE_OP_INC_SKIP && fileRd != ~MIOE_ZERO
    |=> !skipNext_r)
    else $error("nonzero increment armed skip");
  skip_only_inc_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ2
    execNow && instr.op != MIOE_OP_INC_SKIP
    |=> !skipNext_r)
    else $error("skip armed by another operation");
  skip_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ2
    skipNext_r && !cycEn
    |=> skipNext_r)
    else $error("pending skip lost without an instruction");
  skip_squash_w_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ2
    skipNext_r && cycEn
    |=> $stable(wReg_r) && $stable(zero_r) && !fileWr.en && !skipNext_r)
    else $error("squashed instruction had an effect");

  // Increment-skip data path
  inc_dest_w_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ1 RQ10
    execNow && instr.op == MIOE_OP_INC_SKIP && instr.dest == MIOE_DEST_W
    |=> wReg_r == $past(fileRd) + MIOE_ONE && $stable(zero_r) && !fileWr.en)
    else $error("increment to W wrong");
  inc_dest_f_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ1 RQ10
    execNow && instr.op == MIOE_OP_INC_SKIP && instr.dest == MIOE_DEST_F
    |=> fileWr.en && fileWr.data == $past(fileRd) + MIOE_ONE
      && fileWr.addr == $past(instr.addr) && $stable(wReg_r) && $stable(zero_r))
    else $error("increment to file wrong");

  // OR with a literal or a file register
  or_lit_z_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ3 RQ10
    execNow && instr.op == MIOE_OP_OR_LIT
    |=> wReg_r == ($past(wReg_r) | $past(instr.lit))
      && zero_r == (wReg_r == MIOE_ZERO) && !fileWr.en)
    else $error("or literal wrong");
  or_file_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ6 RQ10
    execNow && instr.op == MIOE_OP_OR_FILE && instr.dest == MIOE_DEST_F
    |=> fileWr.en && fileWr.data == ($past(wReg_r) | $past(fileRd))
      && $stable(wReg_r) && zero_r == (fileWr.data == MIOE_ZERO))
    else $error("or file to file wrong");
  or_file_w_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ6 RQ10
    execNow && instr.op == MIOE_OP_OR_FILE && instr.dest == MIOE_DEST_W
    |=> wReg_r == ($past(wReg_r) | $past(fileRd))
      && zero_r == (wReg_r == MIOE_ZERO) && !fileWr.en)
    else $error("or file to W wrong");

  // Literal load and store of the working register
  load_lit_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ4
    execNow && instr.op == MIOE_OP_LOAD_LIT
    |=> wReg_r == $past(instr.lit) && $stable(zero_r) && !fileWr.en)
    else $error("load literal wrong");
  store_w_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ7
    execNow && instr.op == MIOE_OP_STORE_W
    |=> fileWr.en && fileWr.data == $past(wReg_r) && fileWr.addr == $past(instr.addr)
      && $stable(wReg_r) && $stable(zero_r))
    else $error("store working wrong");

  // Move of a file register, to W or back in place
  move_test_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ8 RQ9
    execNow && instr.op == MIOE_OP_MOVE_FILE && instr.dest == MIOE_DEST_F
    |=> fileWr.en && fileWr.data == $past(fileRd) && $stable(wReg_r)
      && zero_r == ($past(fileRd) == MIOE_ZERO))
    else $error("move file test wrong");
  move_to_w_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ8 RQ9
    execNow && instr.op == MIOE_OP_MOVE_FILE && instr.dest == MIOE_DEST_W
    |=> wReg_r == $past(fileRd) && zero_r == ($past(fileRd) == MIOE_ZERO) && !fileWr.en)
    else $error("move file to W wrong");

  // No-operation and cycles without an instruction
  nop_idle_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ11
    cycEn && instr.op == MIOE_OP_NOP
    |=> $stable(wReg_r) && $stable(zero_r) && !fileWr.en && !skipNext_r)
    else $error("no-operation changed state");
  idle_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn) // RQ11
    !cycEn
    |=> $stable(wReg_r) && $stable(zero_r) && $stable(skipNext_r) && !fileWr.en)
    else $error("state changed without an instruction");

  // Main scenarios reached
  skip_taken_c: cover property (@(posedge ref_clk) disable iff (!rstn)
    skipNext_r && cycEn);
  move_zero_c: cover property (@(posedge ref_clk) disable iff (!rstn)
    execNow && instr.op == MIOE_OP_MOVE_FILE && fileRd == MIOE_ZERO);
  or_file_w_c: cover property (@(posedge ref_clk) disable iff (!rstn)
    execNow && instr.op == MIOE_OP_OR_FILE && instr.dest == MIOE_DEST_W);
  inc_wrap_f_c: cover property (@(posedge ref_clk) disable iff (!rstn)
    execNow && instr.op == MIOE_OP_INC_SKIP && instr.dest == MIOE_DEST_F
    && fileRd == ~MIOE_ZERO);
  or_lit_zero_c: cover property (@(posedge ref_clk) disable iff (!rstn)
    execNow && instr.op == MIOE_OP_OR_LIT && (wReg_r | instr.lit) == MIOE_ZERO);
endmodule

// file: test/tb_mcu_move_or_incskip_ops.sv
// Self-checking bench for the move, OR and increment-skip datapath
`timescale 1ns/1ps
module tb_mcu_move_or_incskip_ops;
  import mioe_pkg::*;
  typedef struct packed {
    logic [7:0] w;
    logic z;
    logic s;
    logic en;
    logic [6:0] a;
    logic [7:0] d;
  } mioe_exp_t;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic cycEn = 1'b0;
  mioe_instr_t instr = '0;
  logic [7:0] fileRd = 8'h00;
  mioe_fwr_t fileWr;
  logic [7:0] wReg_r;
  logic zero_r;
  logic skipNext_r;
  mioe_exp_t expQ[$];
  mioe_exp_t m = '0;
  mioe_exp_t got;
  logic [15:0] rnd = 16'h004f;
  logic [7:0] res;
  int fail_count = 0;
  int comparisons = 0;

  mioe_datapath DUT (.ref_clk(ref_clk), .rstn(rstn), .cycEn(cycEn), .instr(instr),
    .fileRd(fileRd), .fileWr(fileWr), .wReg_r(wReg_r), .zero_r(zero_r),
    .skipNext_r(skipNext_r));

  // Shift register source of stimulus
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s seen %h want %h", $time, msg, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Expected state after the edge that takes the current inputs
  task automatic model();
    m.en = 1'b0;
    if (!cycEn) return;
    if (m.s) begin
      m.s = 1'b0;
      return;
    end
    m.a = instr.addr;
    case (instr.op)
      MIOE_OP_INC_SKIP: res = fileRd + 8'h01;
      MIOE_OP_OR_LIT: res = m.w | instr.lit;
      MIOE_OP_OR_FILE: res = m.w | fileRd;
      MIOE_OP_LOAD_LIT: res = instr.lit;
      MIOE_OP_STORE_W: res = m.w;
      MIOE_OP_MOVE_FILE: res = fileRd;
      default: return;
    endcase
    m.d = res;
    if (instr.op inside {MIOE_OP_OR_LIT, MIOE_OP_OR_FILE, MIOE_OP_MOVE_FILE}) m.z = res == 8'h00;
    if (instr.op == MIOE_OP_INC_SKIP) m.s = res == 8'h00;
    if (instr.op == MIOE_OP_STORE_W || (instr.dest && instr.op inside
      {MIOE_OP_INC_SKIP, MIOE_OP_OR_FILE, MIOE_OP_MOVE_FILE})) m.en = 1'b1;
    else m.w = res;
  endtask

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Driver: random instructions at the falling edge, zeros and ff favoured
  initial begin
    repeat (10) @(posedge ref_clk);
    for (int i = 0; i < 3000; i++) begin
      @(negedge ref_clk);
      rstn = 1'b1;
      rnd = lfsr(rnd);
      cycEn = rnd[0] | rnd[1];
      instr.op = mioe_op_t'(3'(rnd[15:8] % 8'd7));
      instr.dest = rnd[5];
      rnd = lfsr(lfsr(lfsr(rnd)));
      instr.addr = rnd[14:8];
      fileRd = rnd[2:0] == 3'h0 ? 8'hff : (rnd[2:0] == 3'h1 ? 8'h00 : rnd[15:8]);
      rnd = lfsr(lfsr(lfsr(rnd)));
      instr.lit = rnd[1:0] == 2'h0 ? 8'h00 : rnd[15:8];
      // Unused fields of a literal load go out as zeros
      if (instr.op == MIOE_OP_LOAD_LIT) begin
        instr.addr = 7'h00;
        instr.dest = 1'b0;
      end
      model();
      expQ.push_back(m);
    end
    @(negedge ref_clk);
    rstn = 1'b0;
    @(posedge ref_clk);
    #1;
    check({wReg_r, zero_r, skipNext_r, fileWr.en}, {MIOE_W_RST, MIOE_Z_RST, 2'b00}, "reset");
    end_sim();
  end

  // Monitor: compares each cycle's outputs with the oldest note
  initial begin
    forever begin
      @(posedge ref_clk);
      #1;
      if (rstn && expQ.size() > 0) begin
        got = expQ.pop_front();
        check(wReg_r, got.w, "w");
        check(zero_r, got.z, "zero");
        check(skipNext_r, got.s, "skip");
        check(fileWr.en, got.en, "wr en");
        if (got.en) check({fileWr.addr, fileWr.data}, {got.a, got.d}, "wr");
      end
    end
  end

  // Watchdog at twice the expected run length
  initial begin
    repeat (6100) @(posedge ref_clk);
    fail_count++;
    end_sim();
  end
endmodule
